// ==== hw/bridge_tail_defs.svh ====
//
// Overview of operation
// - io limit upper half, rw, reset zero
// - capability pointer reads 80h, rest zero
// - expansion rom base always reads zero
// - interrupt routing line rw, reset zero
// - interrupt pin field reads fixed 01h
// - bit 16 enables secondary parity detection in forward mode only
// - forward: bit 16 gates secondary parity response
// - reverse: bit 16 gates poisoned tlp status
// - bit 17 forwards secondary system error, forward mode only (forced zero in reverse)
// - bit 18 sends isa alias range upstream
// - bit 19 forwards vga ranges when enabled
// - bit 20 picks 10 or 16 bit
// - bit 21 clear hides master aborts
// - bit 21 set reports master aborts
// - bit 22 drives secondary or hot reset
// - bit 23 fast back-to-back reads zero
`ifndef BRIDGE_TAIL_DEFS_SVH
`define BRIDGE_TAIL_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_IO_LIM    8'h30
`define OFF_CAP_PTR   8'h34
`define OFF_ROM_BASE  8'h38
`define OFF_INT_CTL   8'h3C
`define OFF_EVT_STAT  8'h50
`define OFF_EVT_CLR   8'h54
`define OFF_EVT_EN    8'h58
// ----------------------------------------
// fields and values
// ----------------------------------------
`define IO_LIM_MSB    31
`define IO_LIM_LSB    16
`define INT_LINE_MSB  7
`define INT_LINE_LSB  0
`define CTL_MSB       23
`define CTL_LSB       16
`define EVT_MSB       3
`define CAP_PTR_VAL   32'h0000_0080
`define ROM_BASE_VAL  32'h0000_0000
`define INT_PIN_VAL   8'h01
`define ZERO32        32'h0000_0000
`define ALL_ONES      32'hFFFF_FFFF
`define CTL_RST       8'h00
`define LINE_RST      8'h00
`define IO_LIM_RST    16'h0000
`define EVT_RST       4'h0
// ----------------------------------------
// address decode constants
// ----------------------------------------
`define ISA_LIMIT     32'h0000_FFFF
`define ISA_ALIAS_M   16'h0300
`define IO10_MASK     16'h03FF
`define VGA_IOA_LO    16'h03B0
`define VGA_IOA_HI    16'h03BB
`define VGA_IOB_LO    16'h03C0
`define VGA_IOB_HI    16'h03DF
`define VGA_MEM_LO    32'h000A_0000
`define VGA_MEM_HI    32'h000B_FFFF
`endif

// ==== hw/bridge_tail_pkg.sv ====
package bridge_tail_pkg;
    // bridge control bits 23 down to 16
    typedef struct packed {
        logic fbb_en;
        logic sec_rst;
        logic mabort_mode;
        logic vga16;
        logic vga_en;
        logic isa_en;
        logic serr_en;
        logic par_en;
    } bridge_ctl_t;

    // sticky event bits
    typedef struct packed {
        logic mabort_rep;
        logic serr_fwd;
        logic poison;
        logic par_err;
    } evt_t;
endpackage : bridge_tail_pkg

// ==== hw/bridge_header_tail_and_control.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "bridge_tail_defs.svh"
module bridge_header_tail_and_control
    import bridge_tail_pkg::*;
(
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // direction strap, high for reverse
    input  wire logic        reverse_strap,
    // command register enables
    input  wire logic        io_space_en,
    input  wire logic        mem_space_en,
    input  wire logic        serr_report_en,
    // secondary side events
    input  wire logic        sec_parity_err,
    input  wire logic        poisoned_tlp,
    input  wire logic        system_error_n,
    // address decode request
    input  wire logic        dec_valid,
    input  wire logic        dec_is_io,
    input  wire logic [31:0] dec_addr,
    input  wire logic        dec_window_hit,
    output logic             fwd_down,
    output logic             fwd_up,
    // master abort handling
    input  wire logic        mabort,
    input  wire logic        mabort_read,
    input  wire logic        mabort_ta_ok,
    output logic             abort_fill_ones,
    output logic             target_abort,
    output logic             primary_system_error_n,
    // error, reset, io limit and interrupt outputs
    output logic             sec_parity_detect_en,
    output logic             data_par_status_set,
    output logic             err_msg_req,
    output logic             sec_bus_reset_n,
    output logic             link_hot_reset,
    output logic [15:0]      io_limit_upper,
    output logic             legacy_interrupt_a_n
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic in_rng16(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_rng16 = (a >= lo) && (a <= hi);
    endfunction : in_rng16

    function automatic logic vga_io_hit(input logic [31:0] a, input logic w16);
        logic [15:0] c;
        c = w16 ? a[15:0] : (a[15:0] & `IO10_MASK);
        vga_io_hit = (!w16 || a <= `ISA_LIMIT)
                     && (in_rng16(c, `VGA_IOA_LO, `VGA_IOA_HI)
                         || in_rng16(c, `VGA_IOB_LO, `VGA_IOB_HI));
    endfunction : vga_io_hit

    // ----------------------------------------
    // state
    // ----------------------------------------
    bridge_ctl_t ctl_r;
    evt_t        stat_r;
    evt_t        en_r;
    logic [7:0]  line_r;
    logic        reverse_r;
    logic        dir_valid_r;
    logic        serr_prev_r;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire acc_start = ce && psel && penable && !pready;
    wire wr_fire   = ce && psel && penable && pready && pwrite;
    wire hit_lim   = paddr == `OFF_IO_LIM;
    wire hit_cap   = paddr == `OFF_CAP_PTR;
    wire hit_rom   = paddr == `OFF_ROM_BASE;
    wire hit_ctl   = paddr == `OFF_INT_CTL;
    wire hit_stat  = paddr == `OFF_EVT_STAT;
    wire hit_clr   = paddr == `OFF_EVT_CLR;
    wire hit_en    = paddr == `OFF_EVT_EN;
    wire mapped    = hit_lim | hit_cap | hit_rom | hit_ctl | hit_stat | hit_clr | hit_en;

    wire bridge_ctl_t ctl_ro = '{fbb_en: 1'b0, sec_rst: ctl_r.sec_rst,
                                 mabort_mode: ctl_r.mabort_mode, vga16: ctl_r.vga16,
                                 vga_en: ctl_r.vga_en, isa_en: ctl_r.isa_en,
                                 serr_en: ctl_r.serr_en, par_en: ctl_r.par_en};
    wire [31:0] rd_ctl  = {8'h00, ctl_ro, `INT_PIN_VAL, line_r};
    wire [31:0] rd_data = hit_lim  ? {io_limit_upper, 16'h0000} :
                          hit_cap  ? `CAP_PTR_VAL :
                          hit_rom  ? `ROM_BASE_VAL :
                          hit_ctl  ? rd_ctl :
                          hit_stat ? {28'h000_0000, stat_r} :
                          hit_en   ? {28'h000_0000, en_r} : `ZERO32;

    // written control byte, fixed and direction-locked bits forced to zero
    wire bridge_ctl_t wr_ctl = pwdata[`CTL_MSB:`CTL_LSB];
    wire bridge_ctl_t ctl_nxt = '{fbb_en: 1'b0,
                                  sec_rst: wr_ctl.sec_rst,
                                  mabort_mode: wr_ctl.mabort_mode,
                                  vga16: wr_ctl.vga16,
                                  vga_en: wr_ctl.vga_en,
                                  isa_en: wr_ctl.isa_en,
                                  serr_en: wr_ctl.serr_en && !reverse_r,
                                  par_en: wr_ctl.par_en};

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `ZERO32;
        end else if (ce) begin
            pready  <= acc_start;
            pslverr <= acc_start && !mapped;
            prdata  <= (acc_start && !pwrite) ? rd_data : `ZERO32;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_limit_upper <= `IO_LIM_RST;
            line_r         <= `LINE_RST;
            ctl_r          <= `CTL_RST;
            en_r           <= `EVT_RST;
        end else if (wr_fire) begin
            if (hit_lim)
                io_limit_upper <= pwdata[`IO_LIM_MSB:`IO_LIM_LSB];
            if (hit_ctl) begin
                line_r <= pwdata[`INT_LINE_MSB:`INT_LINE_LSB];
                ctl_r  <= ctl_nxt;
            end
            if (hit_en)
                en_r <= pwdata[`EVT_MSB:0];
        end
    end

    // direction strap caught on first enabled edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reverse_r   <= 1'b0;
            dir_valid_r <= 1'b0;
        end else if (ce && !dir_valid_r) begin
            reverse_r   <= reverse_strap;
            dir_valid_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // error handling
    // ----------------------------------------
    wire fwd_mode     = dir_valid_r && !reverse_r;
    wire rev_mode     = dir_valid_r && reverse_r;
    wire ev_par       = fwd_mode && ctl_r.par_en && sec_parity_err;
    wire ev_poison    = rev_mode && ctl_r.par_en && poisoned_tlp;
    wire serr_fall    = serr_prev_r && !system_error_n;
    wire ev_serr      = fwd_mode && ctl_r.serr_en && serr_fall;
    wire ev_ta        = mabort && ctl_r.mabort_mode && mabort_ta_ok;
    wire ev_pserr     = mabort && ctl_r.mabort_mode && !mabort_ta_ok
                        && serr_report_en;
    wire ev_ones      = mabort && !ctl_r.mabort_mode && mabort_read;
    wire evt_t ev_now = '{mabort_rep: ev_ta | ev_pserr, serr_fwd: ev_serr,
                          poison: ev_poison, par_err: ev_par};
    wire evt_t clr_w  = (wr_fire && hit_clr) ? evt_t'(pwdata[`EVT_MSB:0]) : evt_t'(`EVT_RST);
    wire evt_t stat_nxt = evt_t'((stat_r & ~clr_w) | ev_now);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serr_prev_r            <= 1'b1;
            stat_r                 <= `EVT_RST;
            sec_parity_detect_en   <= 1'b0;
            data_par_status_set    <= 1'b0;
            err_msg_req            <= 1'b0;
            abort_fill_ones        <= 1'b0;
            target_abort           <= 1'b0;
            primary_system_error_n <= 1'b1;
            legacy_interrupt_a_n   <= 1'b1;
        end else if (ce) begin
            serr_prev_r            <= system_error_n;
            stat_r                 <= stat_nxt;
            sec_parity_detect_en   <= fwd_mode && ctl_r.par_en;
            data_par_status_set    <= ev_poison;
            err_msg_req            <= ev_serr;
            abort_fill_ones        <= ev_ones;
            target_abort           <= ev_ta;
            primary_system_error_n <= !ev_pserr;
            legacy_interrupt_a_n   <= !(|(stat_nxt & en_r));
        end
    end

    // ----------------------------------------
    // forwarding decode and secondary reset
    // ----------------------------------------
    wire isa_alias  = dec_addr <= `ISA_LIMIT && |(dec_addr[15:0] & `ISA_ALIAS_M);
    wire vga_mem    = dec_addr >= `VGA_MEM_LO && dec_addr <= `VGA_MEM_HI;
    wire vga_hit    = ctl_r.vga_en && (dec_is_io
                      ? (io_space_en && vga_io_hit(dec_addr, ctl_r.vga16))
                      : (mem_space_en && vga_mem));
    wire win_down   = dec_window_hit && !(dec_is_io && ctl_r.isa_en && isa_alias);
    wire down_nxt   = dec_valid && (vga_hit || win_down);
    wire up_nxt     = dec_valid && !down_nxt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_down        <= 1'b0;
            fwd_up          <= 1'b0;
            sec_bus_reset_n <= 1'b1;
            link_hot_reset  <= 1'b0;
        end else if (ce) begin
            fwd_down        <= down_nxt;
            fwd_up          <= up_nxt;
            sec_bus_reset_n <= !(ctl_r.sec_rst && fwd_mode);
            link_hot_reset  <= ctl_r.sec_rst && rev_mode;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_io_lim_write: assert property (wr_fire && hit_lim |=>
        io_limit_upper == $past(pwdata[`IO_LIM_MSB:`IO_LIM_LSB]))
        else $error("io limit upper not stored");
    a_cap_ptr_read: assert property (acc_start && !pwrite && hit_cap |=>
        pready && prdata == `CAP_PTR_VAL)
        else $error("capability pointer wrong");
    a_rom_base_zero: assert property (acc_start && !pwrite && hit_rom |=> prdata == `ZERO32)
        else $error("rom base not zero");
    a_int_pin_fbb: assert property (acc_start && !pwrite && hit_ctl |=>
        prdata[15:8] == `INT_PIN_VAL && !prdata[`CTL_MSB])
        else $error("interrupt pin or fast b2b wrong");
    a_poison_gate: assert property (ce && !(rev_mode && ctl_r.par_en) |=> !data_par_status_set)
        else $error("poison flagged while gated");
    a_serr_locked: assert property (rev_mode |-> !ctl_r.serr_en)
        else $error("serr enable set in reverse");
    a_sec_reset: assert property (ce && ctl_r.sec_rst && fwd_mode |=>
        !sec_bus_reset_n && !link_hot_reset)
        else $error("secondary reset not driven");
    a_isa_upstream: assert property (ce && dec_valid && dec_is_io && ctl_r.isa_en && isa_alias
        && !vga_hit |=> !fwd_down && fwd_up)
        else $error("isa alias sent downstream");
    a_abort_hidden: assert property (ce && mabort && !ctl_r.mabort_mode |=>
        !target_abort && primary_system_error_n)
        else $error("master abort reported while hidden");
    a_dir_fixed: assert property (dir_valid_r |=> $stable(reverse_r))
        else $error("direction changed");
endmodule : bridge_header_tail_and_control

// ==== verification/sec_side_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// secondary side event source
// ----------------------------------------
module sec_side_model (
    // clock
    input  wire logic pclk,
    // secondary events
    output logic      sec_parity_err,
    output logic      poisoned_tlp,
    output logic      system_error_n
);
    initial begin
        sec_parity_err = 1'h0;
        poisoned_tlp   = 1'h0;
        system_error_n = 1'h1;
    end

    // one-cycle event; error line goes back to its pull-up level
    task fire(input logic [1:0] kind);
        @(posedge pclk);
        case (kind)
            2'h0: sec_parity_err <= 1'h1;
            2'h1: poisoned_tlp <= 1'h1;
            default: system_error_n <= 1'h0;
        endcase
        @(posedge pclk);
        sec_parity_err <= 1'h0;
        poisoned_tlp   <= 1'h0;
        system_error_n <= 1'h1;
    endtask : fire
endmodule : sec_side_model

// ==== verification/bridge_header_tail_and_control_tb_top.sv ====
`timescale 1ns/1ps
module bridge_header_tail_and_control_tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        pclk, presetn, ce, psel, penable, pwrite, reverse_strap, slverr_seen;
    logic        io_space_en, mem_space_en, serr_report_en, mabort, mabort_read;
    logic        dec_valid, dec_is_io, dec_window_hit, mabort_ta_ok, pready, pslverr;
    logic        sec_parity_err, poisoned_tlp, system_error_n, fwd_down, fwd_up;
    logic        abort_fill_ones, target_abort, primary_system_error_n, err_msg_req;
    logic        sec_parity_detect_en, data_par_status_set, sec_bus_reset_n;
    logic        link_hot_reset, legacy_interrupt_a_n;
    logic [7:0]  paddr;
    logic [15:0] io_limit_upper;
    logic [31:0] pwdata, dec_addr, prdata, rdat;
    int          err_count, samples_checked;

    bridge_header_tail_and_control bridge_header_tail_and_control_inst (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .reverse_strap, .io_space_en, .mem_space_en,
        .serr_report_en, .sec_parity_err, .poisoned_tlp, .system_error_n,
        .dec_valid, .dec_is_io, .dec_addr, .dec_window_hit, .fwd_down, .fwd_up,
        .mabort, .mabort_read, .mabort_ta_ok, .abort_fill_ones, .target_abort,
        .primary_system_error_n, .sec_parity_detect_en, .data_par_status_set,
        .err_msg_req, .sec_bus_reset_n, .link_hot_reset, .io_limit_upper,
        .legacy_interrupt_a_n
    );
    sec_side_model sec_side_model_inst (.pclk, .sec_parity_err, .poisoned_tlp,
        .system_error_n);

    always #2.5 pclk = ~pclk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            err_count++;
            conclude();
        end
        rdat        = prdata;
        slverr_seen = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // let registered outputs follow the write
        @(posedge pclk);
        #1;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0000_0000);
        chk("prdata", exp, rdat);
    endtask : rd

    task dq(input logic io, input logic [31:0] a, input logic hit, input logic down);
        @(posedge pclk);
        dec_valid      <= 1'h1;
        dec_is_io      <= io;
        dec_addr       <= a;
        dec_window_hit <= hit;
        @(posedge pclk);
        dec_valid <= 1'h0;
        #1;
        chk("fwd_down_up", {30'h0, down, !down}, {30'h0, fwd_down, fwd_up});
    endtask : dq

    task ab(input logic ta_ok, input logic [2:0] exp);
        @(posedge pclk);
        mabort       <= 1'h1;
        mabort_read  <= 1'h1;
        mabort_ta_ok <= ta_ok;
        @(posedge pclk);
        mabort <= 1'h0;
        #1;
        chk("abort", exp, {abort_fill_ones, target_abort, primary_system_error_n});
    endtask : ab

    task automatic fire_chk(input logic [1:0] k, input string name, input logic exp,
                            ref logic s);
        sec_side_model_inst.fire(k);
        #1;
        chk(name, exp, s);
    endtask : fire_chk

    task restart(input logic strap);
        @(posedge pclk);
        presetn       <= 1'h0;
        reverse_strap <= strap;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
    endtask : restart

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, reverse_strap, mabort, mabort_read} = 8'h00;
        {dec_valid, dec_is_io, dec_window_hit, mabort_ta_ok, serr_report_en} = 5'h00;
        {ce, io_space_en, mem_space_en} = 3'h7;
        {paddr, pwdata, dec_addr} = 72'h0;
        err_count = 0;
        samples_checked = 0;
        restart(1'h0);
        rd(8'h30, 32'h0000_0000);
        rd(8'h34, 32'h0000_0080);
        rd(8'h38, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0100);
        apb(1'h1, 8'h30, 32'hFFFF_FFFF);
        rd(8'h30, 32'hFFFF_0000);
        chk("io_limit_upper", 32'h0000_FFFF, {16'h0, io_limit_upper});
        apb(1'h1, 8'h34, 32'hFFFF_FFFF);
        rd(8'h34, 32'h0000_0080);
        apb(1'h1, 8'h38, 32'hFFFF_FFFF);
        rd(8'h38, 32'h0000_0000);
        apb(1'h1, 8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h007F_01FF);
        chk("sec_parity_detect_en", 1, sec_parity_detect_en);
        chk("sec_bus_reset_n", 0, sec_bus_reset_n);
        chk("link_hot_reset", 0, link_hot_reset);
        rd(8'h44, 32'h0000_0000);
        chk("pslverr", 1, slverr_seen);
        apb(1'h1, 8'h58, 32'h0000_000F);
        fire_chk(2'h0, "irq_n", 1'h0, legacy_interrupt_a_n);
        rd(8'h50, 32'h0000_0001);
        fire_chk(2'h2, "err_msg_req", 1'h1, err_msg_req);
        apb(1'h1, 8'h54, 32'h0000_000F);
        rd(8'h50, 32'h0000_0000);
        chk("irq_n", 1, legacy_interrupt_a_n);
        apb(1'h1, 8'h58, 32'h0000_0000);
        fire_chk(2'h0, "irq_n", 1'h1, legacy_interrupt_a_n);
        rd(8'h50, 32'h0000_0001);
        apb(1'h1, 8'h3C, 32'h000C_0000);
        chk("sec_parity_detect_en", 0, sec_parity_detect_en);
        dq(1'h1, 32'h0000_03C0, 1'h0, 1'h1);
        dq(1'h1, 32'h0000_13C0, 1'h0, 1'h1);
        dq(1'h1, 32'h0000_0120, 1'h1, 1'h0);
        dq(1'h1, 32'h0000_0450, 1'h1, 1'h1);
        dq(1'h0, 32'h000A_0000, 1'h0, 1'h1);
        apb(1'h1, 8'h3C, 32'h001C_0000);
        dq(1'h1, 32'h0000_13C0, 1'h0, 1'h0);
        ab(1'h1, 3'h5);
        apb(1'h1, 8'h3C, 32'h0020_0000);
        serr_report_en <= 1'h1;
        ab(1'h1, 3'h3);
        ab(1'h0, 3'h0);
        restart(1'h1);
        apb(1'h1, 8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h007D_01FF);
        chk("link_hot_reset", 1, link_hot_reset);
        chk("sec_bus_reset_n", 1, sec_bus_reset_n);
        chk("sec_parity_detect_en", 0, sec_parity_detect_en);
        fire_chk(2'h1, "data_par_status_set", 1'h1, data_par_status_set);
        fire_chk(2'h2, "err_msg_req", 1'h0, err_msg_req);
        conclude();
    end
endmodule : bridge_header_tail_and_control_tb_top
